// ### inc/acl_pkg.sv
// Purpose: Shared constants and types for the aux clock, lock and GPO block.
// Assumes: APB4 register access with 32-bit words.
// Notes: Register byte address is four times the register index.
`default_nettype none
package acl_pkg;
  localparam int ACL_AW = 8;
  localparam int ACL_RW = 24;
  // Register indices and byte addresses.
  localparam logic [7:0] ACL_IDX_AUX1 = 8'h18;
  localparam logic [7:0] ACL_IDX_AUX2 = 8'h19;
  localparam logic [7:0] ACL_IDX_LOCK = 8'h1a;
  localparam logic [7:0] ACL_IDX_GPO = 8'h1b;
  localparam logic [7:0] ACL_IDX_STAT = 8'h1f;
  localparam logic [9:0] ACL_ADDR_AUX1 = {ACL_IDX_AUX1, 2'h0};
  localparam logic [9:0] ACL_ADDR_AUX2 = {ACL_IDX_AUX2, 2'h0};
  localparam logic [9:0] ACL_ADDR_LOCK = {ACL_IDX_LOCK, 2'h0};
  localparam logic [9:0] ACL_ADDR_GPO = {ACL_IDX_GPO, 2'h0};
  localparam logic [9:0] ACL_ADDR_STAT = {ACL_IDX_STAT, 2'h0};
  // Reset values.
  localparam logic [23:0] ACL_RST_AUX1 = 24'h0000a0;
  localparam logic [23:0] ACL_RST_AUX2 = 24'h00000f;
  localparam logic [23:0] ACL_RST_LOCK = 24'h001040;
  localparam logic [23:0] ACL_RST_GPO = 24'h000000;
  // Field positions of the aux registers.
  localparam int ACL_F_INSEL = 0;
  localparam int ACL_F_MODE = 2;
  localparam int ACL_F_DIV = 4;
  localparam int ACL_F_SDSEL = 7;
  localparam int ACL_F_LFSR_EN = 8;
  localparam int ACL_F_ACC_EN = 9;
  localparam int ACL_F_MODMODE = 10;
  localparam int ACL_F_STEP = 12;
  localparam int ACL_F_LODLY = 20;
  localparam int ACL_F_HIDLY = 0;
  localparam int ACL_F_CLKINV = 3;
  localparam int ACL_F_RINGCLK = 4;
  // Field positions of the lock register.
  localparam int ACL_F_THRESH = 0;
  localparam int ACL_F_ASYM = 10;
  localparam int ACL_F_ASYM_POL = 11;
  localparam int ACL_F_AUTO = 12;
  localparam int ACL_F_FORCED = 13;
  localparam int ACL_F_MONO = 14;
  localparam int ACL_F_RSPEED = 15;
  localparam int ACL_F_DUR = 17;
  localparam int ACL_F_RTEST = 19;
  // Field positions of the output select register.
  localparam int ACL_F_GSEL = 0;
  localparam int ACL_F_GDATA = 4;
  localparam int ACL_F_GDRV = 7;
  localparam int ACL_F_GDIS = 8;
  // Status register field positions.
  localparam int ACL_F_ST_LOCK = 0;
  localparam int ACL_F_ST_AUX = 1;
  localparam int ACL_F_ST_SQ = 2;
  typedef enum logic [1:0] {ACL_SRC_VCODIV, ACL_SRC_XREF, ACL_SRC_REFDIV,
    ACL_SRC_RING} acl_src_t;
  typedef enum logic [1:0] {ACL_AM_BYPASS, ACL_AM_DELAY, ACL_AM_RING,
    ACL_AM_RING_GATED} acl_auxmode_t;
  typedef enum logic [1:0] {ACL_MM_PASS, ACL_MM_SQUARE, ACL_MM_LFSR_LO,
    ACL_MM_LFSR_HI} acl_modmode_t;
  // Internal and pin signals used as aux clock sources or routed to the general outputs.
  typedef struct packed {
    logic xref_clk;
    logic xref_sin;
    logic ref_clk;
    logic vco_div_clk;
    logic aux_ring;
    logic lock_ring;
    logic pfd_up;
    logic pfd_dn;
    logic sat_ref;
    logic sat_vco;
    logic cycslip;
    logic frac_strobe;
    logic ramp_busy;
    logic [2:0] vco_phase;
    logic [2:0] quant;
  } acl_src_bus_t;
  // Lock window settings handed to the analog window generator.
  typedef struct packed {
    logic asym_en;
    logic asym_pol;
    logic ring_mono;
    logic [1:0] ring_speed;
    logic [1:0] duration;
    logic ring_test;
  } acl_lock_cfg_t;
endpackage
`default_nettype wire

// ### src/acl_ctrl.sv
// Purpose: Aux clock generator, delay modulator, lock counter and GPO mux.
// Assumes: Clocks from pins are sampled on i_core_clk, well below 50 MHz.
// Notes: APB slave, zero wait states, unmapped addresses answer pslverr.
// Contract
// - Two-bit field picks aux clock source
// - Two-bit field sets aux clock mode
// - Divide aux clock by 1,2,4..14
// - Select bit routes aux clock to modulator
// - Enable bit runs 10-bit LFSR
// - Enable bit runs 8-bit accumulator
// - Two-bit field selects delay modulation mode
// - Accumulator adds step, wrap toggles square
// - Low delay for passthrough and square low
// - High delay is square-wave high level
// - Invert bit inverts modulator clock
// - Ring select clocks LFSR from lock ring
// - Lock after in-window count reaches threshold
// - Asymmetric window enable and polarity bits
// - Auto bit muxes lock to idle data-out
// - Forced bit always drives lock, reads impossible
// - Ring or analog one-shot, speed, duration fields
// - Ring test bit runs ring alone
// - Select zero drives register data on outputs
// - Select codes one to four route signals
// - Further codes route phase, clocks, busy, quantizer
// - Global drive enable, per-pad disable bits
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module acl_ctrl
#(
  parameter int LFSR_W = 10,
  parameter int ACC_W = 8
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Signals from pins and other clocks.
  input wire acl_pkg::acl_src_bus_t i_src,
  input wire logic i_lock_in_window,
  // Serial data out.
  input wire logic i_sdo_read_active,
  input wire logic i_sdo_read_data,
  output logic o_sdo,
  // Generated clocks and modulator.
  output logic o_aux_clk,
  output logic o_sd_clk,
  output logic [2:0] o_aux_delay,
  output logic o_lock_ring_run,
  output acl_pkg::acl_lock_cfg_t o_lock_cfg,
  output logic o_locked,
  // General outputs.
  output logic [2:0] o_gpo,
  output logic [2:0] o_gpo_oe_b
);
  import acl_pkg::*;

  if (LFSR_W != 10 || ACC_W != 8)
  begin : g_width_check
    $error("Modulator widths are fixed at 10 and 8 bits.");
  end

  logic [23:0] aux1_reg;
  logic [23:0] aux2_reg;
  logic [23:0] lock_reg;
  logic [23:0] gpo_reg;
  logic [31:0] prdata_reg;
  acl_src_bus_t src_meta_reg;
  acl_src_bus_t src_reg;
  logic win_meta_reg;
  logic win_reg;
  logic win_dly_reg;
  logic base_dly_reg;
  logic [2:0] div_cnt_reg;
  logic div_clk_reg;
  logic mod_dly_reg;
  logic ring_dly_reg;
  logic [ACC_W-1:0] acc_reg;
  logic sq_reg;
  logic [LFSR_W-1:0] lfsr_reg;
  logic [9:0] win_cnt_reg;
  logic locked_reg;
  logic [2:0] gpo_next;
  logic [2:0] delay_next;
  logic base_clk;
  logic aux_next;
  logic mod_clk;
  logic lfsr_clk;
  logic addr_ok;
  logic wr_en;
  logic [23:0] rd_word;
  logic [ACC_W:0] acc_sum;

  function automatic logic [23:0] merge(input logic [23:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [23:0] r;
    r = old;
    for (int b = 0; b < 3; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] sat_add(input logic [2:0] a,
                                         input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[3] ? 3'h7 : s[2:0];
  endfunction

  // Register access.
  always_comb
  begin
    addr_ok = 1'b1;
    case (i_paddr)
      ACL_ADDR_AUX1: rd_word = aux1_reg;
      ACL_ADDR_AUX2: rd_word = aux2_reg;
      ACL_ADDR_LOCK: rd_word = lock_reg;
      ACL_ADDR_GPO: rd_word = gpo_reg;
      ACL_ADDR_STAT: rd_word = {21'h0, sq_reg, o_aux_clk, locked_reg};
      default:
      begin
        rd_word = 24'h0;
        addr_ok = 1'b0;
      end
    endcase
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign o_prdata = prdata_reg;
  assign wr_en = i_psel & i_penable & i_pwrite & addr_ok;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prdata_reg <= 32'h0;
    end
    else if (i_psel & ~i_penable & ~i_pwrite)
    begin
      prdata_reg <= {8'h0, rd_word};
    end
  end

  // Status register is read only; writes to it are ignored.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      aux1_reg <= ACL_RST_AUX1;
      aux2_reg <= ACL_RST_AUX2;
      lock_reg <= ACL_RST_LOCK;
      gpo_reg <= ACL_RST_GPO;
    end
    else if (wr_en)
    begin
      case (i_paddr)
        ACL_ADDR_AUX1: aux1_reg <= merge(aux1_reg, i_pwdata, i_pstrb);
        ACL_ADDR_AUX2: aux2_reg <= merge(aux2_reg, i_pwdata, i_pstrb);
        ACL_ADDR_LOCK: lock_reg <= merge(lock_reg, i_pwdata, i_pstrb);
        ACL_ADDR_GPO: gpo_reg <= merge(gpo_reg, i_pwdata, i_pstrb);
        default: ;
      endcase
    end
  end

  // Every pin level passes two flip-flops before use.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      src_meta_reg <= '0;
      src_reg <= '0;
      win_meta_reg <= 1'b0;
      win_reg <= 1'b0;
    end
    else
    begin
      src_meta_reg <= i_src;
      src_reg <= src_meta_reg;
      win_meta_reg <= i_lock_in_window;
      win_reg <= win_meta_reg;
    end
  end

  // Aux clock source and mode.
  always_comb
  begin
    case (acl_src_t'(aux1_reg[ACL_F_INSEL +: 2]))
      ACL_SRC_VCODIV: base_clk = src_reg.vco_div_clk;
      ACL_SRC_XREF: base_clk = src_reg.xref_clk;
      ACL_SRC_REFDIV: base_clk = src_reg.ref_clk;
      ACL_SRC_RING: base_clk = src_reg.aux_ring;
      default: base_clk = 1'b0;
    endcase
    case (acl_auxmode_t'(aux1_reg[ACL_F_MODE +: 2]))
      ACL_AM_BYPASS: aux_next = div_clk_reg;
      ACL_AM_DELAY: aux_next = div_clk_reg;
      ACL_AM_RING: aux_next = src_reg.aux_ring;
      ACL_AM_RING_GATED: aux_next = src_reg.aux_ring & div_clk_reg;
      default: aux_next = 1'b0;
    endcase
  end

  // Divide by twice the code toggles every code edges; code zero passes.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      base_dly_reg <= 1'b0;
      div_cnt_reg <= 3'h0;
      div_clk_reg <= 1'b0;
    end
    else
    begin
      base_dly_reg <= base_clk;
      if (aux1_reg[ACL_F_DIV +: 3] == 3'h0)
      begin
        div_clk_reg <= base_clk;
        div_cnt_reg <= 3'h0;
      end
      else if (base_clk & ~base_dly_reg)
      begin
        if (div_cnt_reg + 3'h1 >= aux1_reg[ACL_F_DIV +: 3])
        begin
          div_cnt_reg <= 3'h0;
          div_clk_reg <= ~div_clk_reg;
        end
        else
        begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end

  assign mod_clk = o_aux_clk ^ aux2_reg[ACL_F_CLKINV];
  assign lfsr_clk = aux2_reg[ACL_F_RINGCLK] ? src_reg.lock_ring
                                            : mod_clk;
  assign acc_sum = {1'b0, acc_reg} + {1'b0, aux1_reg[ACL_F_STEP +: 8]};

  // Modulator state advances on rising edges of its own clock.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mod_dly_reg <= 1'b0;
      ring_dly_reg <= 1'b0;
      acc_reg <= '0;
      sq_reg <= 1'b0;
      lfsr_reg <= 10'h001;
    end
    else
    begin
      mod_dly_reg <= mod_clk;
      ring_dly_reg <= lfsr_clk;
      if (aux1_reg[ACL_F_ACC_EN] & mod_clk & ~mod_dly_reg)
      begin
        acc_reg <= acc_sum[ACC_W-1:0];
        if (acc_sum[ACC_W])
        begin
          sq_reg <= ~sq_reg;
        end
      end
      if (aux1_reg[ACL_F_LFSR_EN] & lfsr_clk & ~ring_dly_reg)
      begin
        lfsr_reg <= {lfsr_reg[8:0], lfsr_reg[9] ^ lfsr_reg[6]};
      end
    end
  end

  // Delay code for the analog delay line.
  always_comb
  begin
    case (acl_modmode_t'(aux1_reg[ACL_F_MODMODE +: 2]))
      ACL_MM_PASS: delay_next = aux1_reg[ACL_F_LODLY +: 3];
      ACL_MM_SQUARE: delay_next = sq_reg ? aux2_reg[ACL_F_HIDLY +: 3]
                                  : aux1_reg[ACL_F_LODLY +: 3];
      ACL_MM_LFSR_LO:
        delay_next = sat_add(aux1_reg[ACL_F_LODLY +: 3],
                             {2'h0, lfsr_reg[0]});
      ACL_MM_LFSR_HI:
        delay_next = sat_add(aux1_reg[ACL_F_LODLY +: 3],
                             {1'b0, lfsr_reg[1:0]});
      default: delay_next = 3'h0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_aux_clk <= 1'b0;
      o_sd_clk <= 1'b0;
      o_aux_delay <= 3'h0;
    end
    else
    begin
      o_aux_clk <= aux_next;
      o_sd_clk <= aux1_reg[ACL_F_SDSEL] ? o_aux_clk
                                        : src_reg.vco_div_clk;
      o_aux_delay <= delay_next;
    end
  end

  // Lock counter: one step per reference rising edge, cleared on a miss.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      win_dly_reg <= 1'b0;
      win_cnt_reg <= 10'h0;
      locked_reg <= 1'b0;
    end
    else
    begin
      win_dly_reg <= src_reg.ref_clk;
      if (src_reg.ref_clk & ~win_dly_reg)
      begin
        if (!win_reg)
        begin
          win_cnt_reg <= 10'h0;
          locked_reg <= 1'b0;
        end
        else if (win_cnt_reg >= lock_reg[ACL_F_THRESH +: 10])
        begin
          locked_reg <= 1'b1;
        end
        else
        begin
          win_cnt_reg <= win_cnt_reg + 10'h1;
        end
      end
    end
  end

  assign o_locked = locked_reg;
  assign o_lock_cfg.asym_en = lock_reg[ACL_F_ASYM];
  assign o_lock_cfg.asym_pol = lock_reg[ACL_F_ASYM_POL];
  assign o_lock_cfg.ring_mono = lock_reg[ACL_F_MONO];
  assign o_lock_cfg.ring_speed = lock_reg[ACL_F_RSPEED +: 2];
  assign o_lock_cfg.duration = lock_reg[ACL_F_DUR +: 2];
  assign o_lock_cfg.ring_test = lock_reg[ACL_F_RTEST];
  // Ring runs for the ring one-shot, for testing, or to clock the LFSR.
  assign o_lock_ring_run = lock_reg[ACL_F_RTEST] | lock_reg[ACL_F_MONO] |
                           aux2_reg[ACL_F_RINGCLK];

  // Forced mode hides read data entirely; the host must not read then.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_sdo <= 1'b0;
    end
    else if (lock_reg[ACL_F_FORCED])
    begin
      o_sdo <= locked_reg;
    end
    else if (lock_reg[ACL_F_AUTO] & ~i_sdo_read_active)
    begin
      o_sdo <= locked_reg;
    end
    else
    begin
      o_sdo <= i_sdo_read_data & i_sdo_read_active;
    end
  end

  // General output mux; index 2 is output three.
  always_comb
  begin
    case (gpo_reg[ACL_F_GSEL +: 4])
      4'h0: gpo_next = gpo_reg[ACL_F_GDATA +: 3];
      4'h1: gpo_next = {src_reg.xref_clk, src_reg.ref_clk,
                        src_reg.vco_div_clk};
      4'h2: gpo_next = {src_reg.pfd_up, src_reg.pfd_dn, win_reg};
      4'h3: gpo_next = {src_reg.sat_ref, src_reg.sat_vco,
                        src_reg.cycslip};
      4'h4: gpo_next = {src_reg.xref_clk, src_reg.xref_sin,
                        src_reg.frac_strobe};
      4'h6: gpo_next = src_reg.vco_phase;
      4'h7: gpo_next = {o_aux_clk, src_reg.lock_ring, o_sd_clk};
      4'h8: gpo_next = {1'b0, src_reg.ramp_busy, 1'b0};
      4'ha: gpo_next = src_reg.quant;
      default: gpo_next = 3'h0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_gpo <= 3'h0;
      o_gpo_oe_b <= 3'h7;
    end
    else
    begin
      o_gpo <= gpo_next;
      o_gpo_oe_b <= ~({3{gpo_reg[ACL_F_GDRV]}} &
                      ~gpo_reg[ACL_F_GDIS +: 3]);
    end
  end
endmodule // acl_ctrl
`default_nettype wire

// ### verification/acl_pin_model.sv
// Purpose: Pin-side source levels for the aux clock and GPO block.
// Assumes: The reference toggles every 4 core cycles.
// Notes: Other levels hold 16 cycles so routed values can settle.
`timescale 1ns/1ns
`default_nettype none
module acl_pin_model
  import acl_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Pin levels.
  output acl_pkg::acl_src_bus_t o_src
);
  logic [3:0] cnt_reg;
  logic [31:0] r;
  acl_src_bus_t nxt;
  integer seed = 32'h3a7a47cb;
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_reg <= 4'h0;
      o_src <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 4'h1;
      nxt = o_src;
      r = $random(seed);
      if (cnt_reg == 4'hf)
        nxt = r[$bits(acl_src_bus_t)-1:0];
      if (cnt_reg[1:0] == 2'h3)
        nxt.ref_clk = ~o_src.ref_clk;
      o_src <= nxt;
    end
  end
endmodule // acl_pin_model
`default_nettype wire

// ### verification/acl_ctrl_checker.sv
// Purpose: Concurrent checks on the APB, SDO, lock window and GPO ports.
// Assumes: Single core clock, asynchronous active-low reset.
// Notes: Shadow registers follow APB writes to predict pin levels.
`timescale 1ns/1ns
`default_nettype none
module acl_ctrl_checker
  import acl_pkg::*;
#(
  parameter int LFSR_W = 10,
  parameter int ACC_W = 8
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // Pins.
  input wire acl_pkg::acl_src_bus_t i_src,
  input wire logic i_sdo_read_active,
  input wire logic i_sdo_read_data,
  input wire logic o_sdo,
  input wire acl_pkg::acl_lock_cfg_t o_lock_cfg,
  input wire logic o_locked,
  input wire logic [2:0] o_gpo,
  input wire logic [2:0] o_gpo_oe_b
);
  logic acc;
  logic bad;
  logic [23:0] lk_reg;
  logic [23:0] gp_reg;
  assign acc = i_psel && i_penable;
  assign bad = !(i_paddr inside {ACL_ADDR_AUX1, ACL_ADDR_AUX2,
    ACL_ADDR_LOCK, ACL_ADDR_GPO, ACL_ADDR_STAT});
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lk_reg <= ACL_RST_LOCK;
      gp_reg <= ACL_RST_GPO;
    end
    else if (acc && i_pwrite)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (i_pstrb[b] && i_paddr == ACL_ADDR_LOCK)
          lk_reg[b*8 +: 8] <= i_pwdata[b*8 +: 8];
        if (i_pstrb[b] && i_paddr == ACL_ADDR_GPO)
          gp_reg[b*8 +: 8] <= i_pwdata[b*8 +: 8];
      end
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  unmapped_err_a: assert property (acc && bad |->
    o_pslverr && (i_pwrite || o_prdata == 32'h0))
    else $error("Unmapped access.");
  gpo_data_a: assert property ($past(gp_reg[3:0]) == 4'h0 |->
    o_gpo == $past(gp_reg[6:4])) else $error("GPO data wrong.");
  gpo_reserved_a: assert property ($past(gp_reg[3:0]) inside
    {4'h5, 4'h9, [4'hb:4'hf]} |-> o_gpo == 3'h0)
    else $error("Reserved GPO code drives.");
  gpo_quant_a: assert property ((gp_reg[3:0] == 4'ha &&
    $stable(i_src.quant)) [*4] |-> o_gpo == i_src.quant)
    else $error("Quantizer route wrong.");
  gpo_drive_a: assert property (o_gpo_oe_b ==
    ($past(gp_reg[10:8]) | {3{!$past(gp_reg[7])}}))
    else $error("Pad enable wrong.");
  sdo_forced_a: assert property ($past(lk_reg[13]) |->
    o_sdo == $past(o_locked)) else $error("Forced lock not on SDO.");
  sdo_auto_a: assert property (!$past(lk_reg[13]) &&
    $past(lk_reg[12]) && !$past(i_sdo_read_active) |->
    o_sdo == $past(o_locked)) else $error("Auto lock not on SDO.");
  sdo_read_a: assert property (!$past(lk_reg[13]) &&
    $past(i_sdo_read_active) |-> o_sdo == $past(i_sdo_read_data))
    else $error("Read data not on SDO.");
  lock_cfg_a: assert property (o_lock_cfg ==
    {lk_reg[10], lk_reg[11], lk_reg[14], lk_reg[16:15], lk_reg[18:17],
    lk_reg[19]})
    else $error("Lock window settings wrong.");
endmodule // acl_ctrl_checker
bind acl_ctrl acl_ctrl_checker #(.LFSR_W(LFSR_W), .ACC_W(ACC_W))
  acl_ctrl_checker_i (.i_core_clk, .i_rst_b, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pslverr,
  .i_src, .i_sdo_read_active, .i_sdo_read_data, .o_sdo, .o_lock_cfg,
  .o_locked, .o_gpo, .o_gpo_oe_b);
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for the aux clock, lock and GPO block.
// Assumes: Zero-wait APB slave on a 100 MHz core clock.
// Notes: Read results are compared from a queue by a monitor.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import acl_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [9:0] i_paddr = 10'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_pstrb = 4'h0;
  logic i_lock_in_window = 1'b0;
  logic i_sdo_read_active = 1'b0;
  logic i_sdo_read_data = 1'b0;
  acl_src_bus_t i_src;
  acl_lock_cfg_t o_lock_cfg;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_sdo, o_locked;
  logic o_aux_clk, o_sd_clk, o_lock_ring_run;
  logic [2:0] o_aux_delay, o_gpo, o_gpo_oe_b;
  int n_mismatch = 0;
  int n_compared = 0;
  integer seed = 32'h3a7a47cb;
  logic [23:0] shadow [4] = '{ACL_RST_AUX1, ACL_RST_AUX2, ACL_RST_LOCK,
    ACL_RST_GPO};
  logic [32:0] exp_q [$];
  logic [32:0] msk_q [$];
  logic [32:0] mon_m;

  always #5 i_core_clk = ~i_core_clk;

  acl_pin_model acl_pin_model_i (.i_core_clk, .i_rst_b, .o_src(i_src));
  acl_ctrl acl_ctrl_i (.i_core_clk, .i_rst_b, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready,
    .o_pslverr, .i_src, .i_lock_in_window, .i_sdo_read_active,
    .i_sdo_read_data, .o_sdo, .o_aux_clk, .o_sd_clk, .o_aux_delay,
    .o_lock_ring_run, .o_lock_cfg, .o_locked, .o_gpo, .o_gpo_oe_b);

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    test_done();
  endtask

  // The slave answers with no wait states, but the wait stays bounded.
  task automatic apb(input logic w, input logic [9:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [32:0] e,
    input logic [32:0] m);
    int k;
    k = 0;
    @(posedge i_core_clk);
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20)
      give_up();
    if (w && a >= ACL_ADDR_AUX1 && a <= ACL_ADDR_GPO)
      for (int b = 0; b < 3; b++)
        if (s[b])
          shadow[(a - ACL_ADDR_AUX1) >> 2][b*8 +: 8] = d[b*8 +: 8];
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rd(input int j);
    apb(1'b0, ACL_ADDR_AUX1 + 10'(4 * j), 32'h0, 4'hf,
      {9'h0, shadow[j]}, '1);
  endtask

  task automatic wait_ref(input int n);
    int k;
    logic prev;
    k = 0;
    prev = i_src.ref_clk;
    while (n > 0 && k < 200)
    begin
      @(negedge i_core_clk);
      k++;
      if (i_src.ref_clk && !prev)
        n--;
      prev = i_src.ref_clk;
    end
    if (n > 0)
      give_up();
  endtask

  // Measures the aux clock between its second and third rising edges, so
  // the transient after a reconfiguration does not count.
  task automatic aux_period(input int want);
    int k;
    int n;
    int t0;
    logic prev;
    k = 0;
    n = 0;
    t0 = 0;
    prev = o_aux_clk;
    while (n < 3 && k < 500)
    begin
      @(negedge i_core_clk);
      k++;
      check({32'h0, o_sd_clk}, {32'h0, prev});
      if (o_aux_clk && !prev)
      begin
        n++;
        if (n == 3)
          check(33'(k - t0), 33'(want));
        t0 = k;
      end
      prev = o_aux_clk;
    end
    if (n < 3)
      give_up();
  endtask

  function automatic logic [2:0] route(input logic [3:0] c,
    input acl_src_bus_t s);
    case (c)
      4'h3: return {s.sat_ref, s.sat_vco, s.cycslip};
      4'h4: return {s.xref_clk, s.xref_sin, s.frac_strobe};
      4'h8: return {1'b0, s.ramp_busy, 1'b0};
      4'ha: return s.quant;
      default: return 3'h0;
    endcase
  endfunction

  always @(posedge i_core_clk)
    if (i_psel && i_penable && o_pready && !i_pwrite && exp_q.size() > 0)
    begin
      mon_m = msk_q.pop_front();
      check({o_pslverr, o_prdata} & mon_m,
        exp_q.pop_front() & mon_m);
    end

  initial
  begin
    logic [31:0] r;
    logic [3:0] codes [8];
    logic [2:0] msk;
    int k;
    codes = '{4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int j = 0; j < 4; j++)
      rd(j);
    repeat (6)
      for (int j = 0; j < 4; j++)
      begin
        r = $random(seed);
        apb(1'b1, ACL_ADDR_AUX1 + 10'(4 * j), r, 4'($random(seed)), 0, 0);
        rd(j);
      end
    apb(1'b1, 10'h070, 32'hffffffff, 4'hf, 33'h0, 33'h0);
    apb(1'b0, 10'h070, 32'h0, 4'hf, {1'b1, 32'h0}, '1);
    apb(1'b1, ACL_ADDR_STAT, 32'hffffffff, 4'hf, 33'h0, 33'h0);
    apb(1'b0, ACL_ADDR_STAT, 32'h0, 4'hf, 33'h0, {30'h3fffffff, 3'h0});
    for (int v = 0; v < 8; v++)
    begin
      r = {21'h0, 3'(v ^ 3), v[0] | v[1], 3'(v), 4'h0};
      apb(1'b1, ACL_ADDR_GPO, r, 4'hf, 33'h0, 33'h0);
      repeat (2) @(negedge i_core_clk);
      check({30'h0, o_gpo}, 33'(v));
      check({30'h0, o_gpo_oe_b}, {30'h0, r[10:8] | {3{!r[7]}}});
    end
    foreach (codes[j])
    begin
      msk = (codes[j] == 4'h8) ? 3'h2 : 3'h7;
      apb(1'b1, ACL_ADDR_GPO, {24'h0, 4'h8, codes[j]}, 4'hf, 0, 0);
      // The new select reaches the outputs one edge after the write.
      @(posedge i_core_clk);
      k = 0;
      // Sample mid-hold so the pin levels have crossed the synchroniser.
      do
      begin
        @(negedge i_core_clk);
        k++;
      end while (acl_pin_model_i.cnt_reg !== 4'h5 && k < 40);
      if (k >= 40)
        give_up();
      check({30'h0, o_gpo & msk},
        {30'h0, route(codes[j], i_src) & msk});
    end
    apb(1'b1, ACL_ADDR_AUX1, 32'h5000a0, 4'hf, 33'h0, 33'h0);
    repeat (4) @(negedge i_core_clk);
    check({30'h0, o_aux_delay}, 33'h5);
    // Reference source, every divider code; the reference period is 8.
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, ACL_ADDR_AUX1, 32'h500082 | 32'(c * 16 + c % 2 * 4), 4'hf,
        33'h0, 33'h0);
      aux_period(8 * ((c == 0) ? 1 : 2 * c));
    end
    apb(1'b1, ACL_ADDR_LOCK, 32'h001003, 4'hf, 33'h0, 33'h0);
    i_lock_in_window <= 1'b1;
    wait_ref(3);
    repeat (4) @(negedge i_core_clk);
    check({32'h0, o_locked}, 33'h0);
    wait_ref(1);
    repeat (5) @(negedge i_core_clk);
    check({32'h0, o_locked}, 33'h1);
    check({32'h0, o_sdo}, 33'h1);
    apb(1'b0, ACL_ADDR_STAT, 32'h0, 4'hf, 33'h1, 33'h1);
    i_sdo_read_active <= 1'b1;
    repeat (2) @(negedge i_core_clk);
    check({32'h0, o_sdo}, 33'h0);
    @(posedge i_core_clk);
    i_sdo_read_data <= 1'b1;
    repeat (2) @(negedge i_core_clk);
    check({32'h0, o_sdo}, 33'h1);
    @(posedge i_core_clk);
    i_sdo_read_active <= 1'b0;
    // No serial read is attempted while the lock is forced onto SDO.
    apb(1'b1, ACL_ADDR_LOCK, 32'h002003, 4'hf, 33'h0, 33'h0);
    repeat (2) @(negedge i_core_clk);
    check({32'h0, o_sdo}, 33'h1);
    apb(1'b1, ACL_ADDR_LOCK, 32'h000003, 4'hf, 33'h0, 33'h0);
    repeat (2) @(negedge i_core_clk);
    check({32'h0, o_sdo}, 33'h0);
    @(posedge i_core_clk);
    i_lock_in_window <= 1'b0;
    wait_ref(2);
    repeat (5) @(negedge i_core_clk);
    check({32'h0, o_locked}, 33'h0);
    apb(1'b1, ACL_ADDR_LOCK, 32'h080000, 4'hf, 33'h0, 33'h0);
    @(negedge i_core_clk);
    check({32'h0, o_lock_ring_run}, 33'h1);
    test_done();
  end
endmodule // testbench
`default_nettype wire
